// ---- src/tsm_mux.sv ----
// Contract
// - bits 7:6 pick load-modulation pin source; 00 leaves pin tristate
// - load-mod field 11 drives chosen test signal from test-select register
// - bits 5:4 pick both antenna driver sources; 00 tristates both
// - field value 01 routes internal coder envelope
// - field value 10 routes envelope from external signal input
// - select fields live in one read/write byte register at 6306h
// - driver field 11 drives static high, polarity set by inversion bits
// - bits 3:0 pick signal output: off, low, high, bus, coder, serial, rx
//
// Design decision made here: register access over AHB-Lite.
`default_nettype none
module tsm_mux (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // internal sources
   input  wire logic        coder_envelope,
   input  wire logic        external_envelope_input,
   input  wire logic [3:0]  load_mod_test_sources,
   input  wire logic [7:0]  test_bus,
   input  wire logic        serial_tx_data,
   input  wire logic        receiver_regen,
   // inversion controls from the driver control register
   input  wire logic        rf_enable_one,
   input  wire logic        rf_enable_two,
   input  wire logic        invert_driver_one_field_on,
   input  wire logic        invert_driver_one_field_off,
   input  wire logic        invert_driver_two_field_on,
   input  wire logic        invert_driver_two_field_off,
   // pins
   output tsm_pkg::tsm_pin_t load_modulation_pin,
   output tsm_pkg::tsm_pin_t antenna_driver_one,
   output tsm_pkg::tsm_pin_t antenna_driver_two,
   output tsm_pkg::tsm_pin_t external_signal_output
);
   tsm_pkg::tsm_sel_t sel_ff, nxt_sel;
   logic [7:0]        test_ff, nxt_test;
   logic              wr_pend_ff, nxt_wr_pend;
   logic [17:0]       waddr_ff, nxt_waddr;
   logic [31:0]       rdata_ff, nxt_rdata;
   logic              addr_ok;
   tsm_pkg::tsm_pin_t nxt_lm, nxt_t1, nxt_t2, nxt_so;
   tsm_pkg::tsm_pin_t lm_ff, t1_ff, t2_ff, so_ff;
   logic              inv1, inv2;
   logic [1:0]        lm_test_choice;
   logic [2:0]        test_bus_bit_choice;

   assign addr_ok   = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_ff;
   assign lm_test_choice      = test_ff[5:4];
   assign test_bus_bit_choice = test_ff[2:0];

   // bus: writes land in the data phase, reads are registered one cycle after address
   always_comb begin
      nxt_sel     = sel_ff;
      nxt_test    = test_ff;
      nxt_wr_pend = addr_ok & hwrite;
      nxt_waddr   = haddr[17:0];
      nxt_rdata   = 32'h0000_0000;
      if (wr_pend_ff) begin
         if (waddr_ff == tsm_pkg::TSM_SEL_ADDR) begin
            nxt_sel = hwdata[7:0];
         end else if (waddr_ff == tsm_pkg::TSM_TEST_ADDR) begin
            nxt_test = hwdata[7:0];
         end
      end
      // read from next values: a write still in its data phase must be seen by the read after it
      if (addr_ok && !hwrite) begin
         if (haddr[17:0] == tsm_pkg::TSM_SEL_ADDR) begin
            nxt_rdata = {24'h00_0000, nxt_sel};
         end else if (haddr[17:0] == tsm_pkg::TSM_TEST_ADDR) begin
            nxt_rdata = {24'h00_0000, nxt_test};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_ff     <= tsm_pkg::TSM_SEL_RESET;
         test_ff    <= tsm_pkg::TSM_TEST_RESET;
         wr_pend_ff <= 1'b0;
         waddr_ff   <= 18'h0_0000;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         sel_ff     <= nxt_sel;
         test_ff    <= nxt_test;
         wr_pend_ff <= nxt_wr_pend;
         waddr_ff   <= nxt_waddr;
         rdata_ff   <= nxt_rdata;
      end
   end

   // polarity of the static high level follows field state per driver
   assign inv1 = rf_enable_one ? invert_driver_one_field_on : invert_driver_one_field_off;
   assign inv2 = rf_enable_two ? invert_driver_two_field_on : invert_driver_two_field_off;

   // muxes decode the stored byte only, so a write switches in one step
   always_comb begin
      nxt_lm = '{level: 1'b0, oe: 1'b1};
      case (sel_ff.load_mod_source_field)
         tsm_pkg::TSM_SRC_OFF:   nxt_lm = '{level: 1'b0, oe: 1'b0};
         tsm_pkg::TSM_SRC_CODER: nxt_lm.level = coder_envelope;
         tsm_pkg::TSM_SRC_EXTERNAL_ENVELOPE_INPUT: nxt_lm.level = external_envelope_input;
         tsm_pkg::TSM_SRC_AUX:   nxt_lm.level = load_mod_test_sources[lm_test_choice];
         default:                nxt_lm = '{level: 1'b0, oe: 1'b0};
      endcase
      nxt_t1 = '{level: 1'b0, oe: 1'b1};
      nxt_t2 = '{level: 1'b0, oe: 1'b1};
      case (sel_ff.antenna_driver_source_field)
         tsm_pkg::TSM_SRC_OFF: begin
            nxt_t1.oe = 1'b0;
            nxt_t2.oe = 1'b0;
         end
         tsm_pkg::TSM_SRC_CODER: begin
            nxt_t1.level = coder_envelope;
            nxt_t2.level = coder_envelope;
         end
         tsm_pkg::TSM_SRC_EXTERNAL_ENVELOPE_INPUT: begin
            nxt_t1.level = external_envelope_input;
            nxt_t2.level = external_envelope_input;
         end
         tsm_pkg::TSM_SRC_AUX: begin
            nxt_t1.level = ~inv1;
            nxt_t2.level = ~inv2;
         end
         default: begin
            nxt_t1.oe = 1'b0;
            nxt_t2.oe = 1'b0;
         end
      endcase
      nxt_so = '{level: 1'b0, oe: 1'b1};
      case (sel_ff.signal_output_source_field)
         tsm_pkg::TSM_SO_OFF:   nxt_so.oe = 1'b0;
         tsm_pkg::TSM_SO_LOW:   nxt_so.level = 1'b0;
         tsm_pkg::TSM_SO_HIGH:  nxt_so.level = 1'b1;
         tsm_pkg::TSM_SO_TBUS:  nxt_so.level = test_bus[test_bus_bit_choice];
         tsm_pkg::TSM_SO_CODER: nxt_so.level = coder_envelope;
         tsm_pkg::TSM_SO_SER:   nxt_so.level = serial_tx_data;
         tsm_pkg::TSM_SO_RX:    nxt_so.level = receiver_regen;
         // undefined codes park the pin in tristate
         default:               nxt_so.oe = 1'b0;
      endcase
   end

   // pins registered: applied the cycle after the select register updates
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lm_ff <= '{level: 1'b0, oe: 1'b0};
         t1_ff <= '{level: 1'b0, oe: 1'b1};
         t2_ff <= '{level: 1'b0, oe: 1'b1};
         so_ff <= '{level: 1'b0, oe: 1'b0};
      end else begin
         lm_ff <= nxt_lm;
         t1_ff <= nxt_t1;
         t2_ff <= nxt_t2;
         so_ff <= nxt_so;
      end
   end

   assign load_modulation_pin    = lm_ff;
   assign antenna_driver_one     = t1_ff;
   assign antenna_driver_two     = t2_ff;
   assign external_signal_output = so_ff;

   a_lm_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(sel_ff.load_mod_source_field) == 2'h0 |-> !load_modulation_pin.oe)
      else $error("load-mod pin driven while source off");
   a_lm_test_src: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(sel_ff.load_mod_source_field) == 2'h3 |->
      load_modulation_pin.level == $past(load_mod_test_sources[lm_test_choice]))
      else $error("load-mod test source wrong");
   a_drv_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(sel_ff.antenna_driver_source_field) == 2'h0 |->
      !antenna_driver_one.oe && !antenna_driver_two.oe)
      else $error("drivers not tristate");
   // pins still show reset values one edge after release, whatever the coder does
   a_coder_route: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(hresetn) && $past(sel_ff.antenna_driver_source_field) == 2'h1 |->
      antenna_driver_two.level == $past(coder_envelope) && antenna_driver_one.oe)
      else $error("coder envelope not on drivers");
   a_external_envelope_input_route: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(sel_ff.load_mod_source_field) == 2'h2 |->
      load_modulation_pin.level == $past(external_envelope_input))
      else $error("input envelope not on load-mod pin");
   a_reg_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_ff && waddr_ff == tsm_pkg::TSM_SEL_ADDR |=> sel_ff == $past(hwdata[7:0]))
      else $error("select register write lost");
   a_static_high: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(sel_ff.antenna_driver_source_field) == 2'h3 |->
      antenna_driver_one.level == !$past(inv1))
      else $error("static high polarity wrong");
   a_external_signal_output_high: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(sel_ff.signal_output_source_field) == 4'h2 |->
      external_signal_output.oe && external_signal_output.level)
      else $error("signal output not high");
   a_tbus_route: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(sel_ff.signal_output_source_field) == 4'h3 |->
      external_signal_output.oe &&
      external_signal_output.level == $past(test_bus[test_bus_bit_choice]))
      else $error("test bus bit not on signal output");
   a_apply_next: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_ff && waddr_ff == tsm_pkg::TSM_SEL_ADDR && hwdata[5:4] == 2'h0 |=> ##1
      !antenna_driver_one.oe)
      else $error("driver select not applied in time");
   c_lm_test: cover property (@(posedge hclk) sel_ff.load_mod_source_field == 2'h3);
   c_drv_high: cover property (@(posedge hclk) sel_ff.antenna_driver_source_field == 2'h3);
   c_so_rx: cover property (@(posedge hclk) sel_ff.signal_output_source_field == 4'h6);
   c_drv_off: cover property (@(posedge hclk) sel_ff.antenna_driver_source_field == 2'h0);
endmodule
`default_nettype wire

// ---- src/tsm_pkg.sv ----
`default_nettype none
package tsm_pkg;
   // register map: printed offset 6306h is not a multiple of four, so it is an index
   localparam logic [15:0] TSM_SEL_INDEX  = 16'h6306;
   localparam logic [17:0] TSM_SEL_ADDR   = {TSM_SEL_INDEX, 2'h0};
   // test-source register of this block (address of own choosing)
   localparam logic [17:0] TSM_TEST_ADDR  = 18'h18C20;
   localparam logic [7:0]  TSM_SEL_RESET  = 8'h10;
   localparam logic [7:0]  TSM_TEST_RESET = 8'h00;
   localparam int          TSM_LM_LSB     = 6;
   localparam int          TSM_DRV_LSB    = 4;
   localparam int          TSM_SIG_LSB    = 0;
   localparam logic [1:0]  TSM_SRC_OFF    = 2'h0;
   localparam logic [1:0]  TSM_SRC_CODER  = 2'h1;
   localparam logic [1:0]  TSM_SRC_EXTERNAL_ENVELOPE_INPUT  = 2'h2;
   localparam logic [1:0]  TSM_SRC_AUX    = 2'h3;
   localparam logic [3:0]  TSM_SO_OFF     = 4'h0;
   localparam logic [3:0]  TSM_SO_LOW     = 4'h1;
   localparam logic [3:0]  TSM_SO_HIGH    = 4'h2;
   localparam logic [3:0]  TSM_SO_TBUS    = 4'h3;
   localparam logic [3:0]  TSM_SO_CODER   = 4'h4;
   localparam logic [3:0]  TSM_SO_SER     = 4'h5;
   localparam logic [3:0]  TSM_SO_RX      = 4'h6;

   typedef struct packed {
      logic [1:0] load_mod_source_field;
      logic [1:0] antenna_driver_source_field;
      logic [3:0] signal_output_source_field;
   } tsm_sel_t;

   // one pin as level plus output enable
   typedef struct packed {
      logic level;
      logic oe;
   } tsm_pin_t;
endpackage
`default_nettype wire

// ---- tb/tsm_far_side.sv ----
`default_nettype none
module tsm_far_side (
   // clock
   input  wire logic       hclk,
   // pins as {level,oe} pairs
   input  wire logic [7:0] pins,
   // levels seen on the wires
   output logic      [3:0] line
);
   logic [3:0] last_ff;
   // a released line shows the inverse of its last level, so a stale value never matches
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         line[k] = pins[2*k] ? pins[2*k+1] : ~last_ff[k];
      end
   end
   always_ff @(posedge hclk) begin
      last_ff <= line;
   end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] SEL = {14'h0, tsm_pkg::TSM_SEL_ADDR};
   localparam logic [31:0] TST = {14'h0, tsm_pkg::TSM_TEST_ADDR};
   logic              hclk, hresetn, hsel, hwrite, coder, env, ser, rx, rf1, i1on, i2off;
   logic              rf2, i1off, i2on;
   logic       [31:0] haddr, hwdata, rd;
   logic       [1:0]  htrans;
   logic       [2:0]  hsize;
   logic       [3:0]  lmt;
   logic       [7:0]  tbus;
   wire logic  [31:0] hrdata;
   wire logic         hrdy;
   wire logic         hresp;
   wire logic  [3:0]  line;
   wire tsm_pkg::tsm_pin_t lm_p, d1_p, d2_p, so_p;
   wire logic  [3:0]  oe_now = {lm_p.oe, d1_p.oe, d2_p.oe, so_p.oe};
   int                err_total = 0, checked = 0, cyc = 0;

   tsm_mux dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp,
      .coder_envelope(coder), .external_envelope_input(env),
      .load_mod_test_sources(lmt), .test_bus(tbus), .serial_tx_data(ser),
      .receiver_regen(rx), .rf_enable_one(rf1), .rf_enable_two(rf2),
      .invert_driver_one_field_on(i1on), .invert_driver_one_field_off(i1off),
      .invert_driver_two_field_on(i2on), .invert_driver_two_field_off(i2off),
      .load_modulation_pin(lm_p), .antenna_driver_one(d1_p),
      .antenna_driver_two(d2_p), .external_signal_output(so_p)
   );
   tsm_far_side far (.hclk, .pins({lm_p, d1_p, d2_p, so_p}), .line);

   initial begin
      hclk = 1'h0;
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hrdy !== 1'h1) @(posedge hclk);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hrdy !== 1'h1) @(posedge hclk);
      rd = hrdata;
   endtask
   // expected {oe, level} of load-mod, driver one, driver two, signal out
   function automatic logic [7:0] want(input logic [7:0] s);
      logic [3:0] oe;
      logic [3:0] lv;
      oe = 4'hF;
      lv = 4'h0;
      case (s[7:6])
         2'h0: oe[3] = 1'h0;
         2'h1: lv[3] = coder;
         2'h2: lv[3] = env;
         default: lv[3] = lmt[2];
      endcase
      case (s[5:4])
         2'h0: oe[2:1] = 2'h0;
         2'h1: lv[2:1] = {2{coder}};
         2'h2: lv[2:1] = {2{env}};
         default: lv[2:1] = {~(rf1 ? i1on : i1off), ~(rf2 ? i2on : i2off)};
      endcase
      case (s[3:0])
         4'h1: lv[0] = 1'h0;
         4'h2: lv[0] = 1'h1;
         4'h3: lv[0] = tbus[2];
         4'h4: lv[0] = coder;
         4'h5: lv[0] = ser;
         4'h6: lv[0] = rx;
         default: oe[0] = 1'h0;
      endcase
      return {oe, lv};
   endfunction
   task automatic pins_chk(input logic [7:0] s);
      logic [7:0] w;
      w = want(s);
      chk({28'h0, oe_now}, {28'h0, w[7:4]});
      chk({28'h0, line & w[7:4]}, {28'h0, w[3:0] & w[7:4]});
   endtask

   task automatic t_reset();
      bus(1'h0, SEL, 32'h0);
      chk(rd, 32'h10);
      chk({31'h0, hresp}, 32'h0);
      pins_chk(8'h10);
      $display("reset test done");
   endtask
   task automatic t_rereset();
      @(posedge hclk);
      hresetn <= 1'h0;
      @(posedge hclk);
      hresetn <= 1'h1;
      bus(1'h0, SEL, 32'h0);
      chk(rd, 32'h10);
      bus(1'h0, TST, 32'h0);
      chk(rd, 32'h0);
      pins_chk(8'h10);
      $display("mid-run reset test done");
   endtask
   task automatic t_unmapped();
      bus(1'h1, 32'h100, 32'hFF);
      bus(1'h0, 32'h100, 32'h0);
      chk(rd, 32'h0);
      bus(1'h0, SEL, 32'h0);
      chk(rd, 32'h10);
      $display("unmapped test done");
   endtask
   task automatic t_mux();
      logic [7:0] s;
      bus(1'h1, TST, 32'h22);
      bus(1'h0, TST, 32'h0);
      chk(rd, 32'h22);
      // two-bit field codes twice each, signal codes 0000-0111 once each, undefined 0111 last
      for (int i = 0; i < 8; i++) begin
         s = {i[1:0], ~i[1:0], i[3:0]};
         coder <= i[0];
         env   <= ~i[0];
         ser   <= i[1];
         rx    <= ~i[1];
         rf1   <= i[2];
         rf2   <= ~i[2];
         // on and off inversion bits differ whenever the driver field is 11, so a wrong pick shows
         i1on  <= (s[5:4] == 2'h3) & i[2];
         i1off <= (s[5:4] == 2'h3) & ~i[2];
         i2on  <= (s[5:4] == 2'h3) & i[2];
         i2off <= (s[5:4] == 2'h3) & ~i[2];
         lmt   <= 4'h4 ^ {4{i[0]}};
         tbus  <= 8'h04 ^ {8{i[1]}};
         bus(1'h1, SEL, {24'h0, s});
         @(posedge hclk);
         #1;
         pins_chk(s);
         bus(1'h0, SEL, 32'h0);
         chk(rd, {24'h0, s});
      end
      $display("mux test done");
   endtask

   initial begin
      {hresetn, hsel, hwrite, coder, env, ser, rx, rf1, i1on, i2off} = '0;
      {rf2, i1off, i2on} = '0;
      {lmt, tbus, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      t_reset();
      t_unmapped();
      t_mux();
      t_rereset();
      final_report();
   end
endmodule
`default_nettype wire
